/* File: src/ddr_strobe_delay_control.sv */
// DDR strobe delay control: two calibration loops, read strobe delay and
// capture controls, write gear clocks and leveled write strobe, APB registers.
// Assumes strobe pads and loop phase detectors are asynchronous to pclk and
// that the fabric controller drives write leveling through the registers.
//
// Function
// - Left loop banks 0,7,6; right 1,2,3
// - Each loop hands out a 7-bit code
// - Loops track drift continuously via feedback
// - Only strobe-capable pads reach the strobe path
// - Read strobe delayed a quarter period by code
// - Delayed strobe fans out to 10/11 pads
// - Read side makes capture polarity select
// - Double-rate gearbox gets stage transfer strobe
// - Write side makes two gearing clocks
// - Write strobe delayed by code plus setting
// - Write setting selects 128 delay steps
// - Setting top bit inverts, 180 degree shift
// - Delayed, inverted result is the write strobe
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module ddr_strobe_delay_control (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [ddr_strobe_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [ddr_strobe_pkg::DATA_W-1:0]   pwdata,
    output logic      [ddr_strobe_pkg::DATA_W-1:0]   prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [ddr_strobe_pkg::PAD_N-1:0]    strobe_pad_in,
    input  wire logic [1:0]                          dll_lag,
    output logic      [ddr_strobe_pkg::CODE_W-1:0]   dll_delay_code_left,
    output logic      [ddr_strobe_pkg::CODE_W-1:0]   dll_delay_code_right,
    output logic      [ddr_strobe_pkg::DQ_N-1:0]     read_strobe_delayed,
    output logic                                     capture_clock_polarity,
    output logic                                     gearbox_transfer_strobe,
    output logic                                     write_gear_clock_0,
    output logic                                     write_gear_clock_1,
    output logic                                     write_strobe_shifted
);

    // Pad and phase detector synchronisers
    logic [ddr_strobe_pkg::PAD_N-1:0] pad_s1_ff;  // First stage, read only by second
    logic [ddr_strobe_pkg::PAD_N-1:0] pad_s2_ff;  // Safe pad levels
    logic [1:0]                       lag_s1_ff;  // First stage of loop feedback
    logic [1:0]                       lag_s2_ff;  // Safe loop feedback

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_s1_ff <= '0;
            pad_s2_ff <= '0;
            lag_s1_ff <= '0;
            lag_s2_ff <= '0;
        end else begin
            pad_s1_ff <= strobe_pad_in;
            pad_s2_ff <= pad_s1_ff;
            lag_s1_ff <= dll_lag;
            lag_s2_ff <= lag_s1_ff;
        end
    end

    // APB register state
    ddr_strobe_pkg::ctrl_t                ctrl_ff, nxt_ctrl;      // Control fields
    logic [ddr_strobe_pkg::WL_W-1:0]      wl_ff, nxt_wl;          // Write leveling setting
    logic [ddr_strobe_pkg::DATA_W-1:0]    prdata_ff, nxt_prdata;  // Read data
    logic                                 pready_ff, nxt_pready;  // Access phase answer
    logic                                 pslverr_ff, nxt_pslverr;
    logic                                 wr_access;              // Write completes now
    logic                                 addr_hit;               // Mapped address

    // Block state read back over the bus
    logic [ddr_strobe_pkg::CODE_W-1:0]    cal_code_ff [2];        // Loop codes, 0 left
    logic [ddr_strobe_pkg::CODE_W-1:0]    rd_code_ff;             // Code in use, read
    logic [ddr_strobe_pkg::CODE_W-1:0]    wr_code_ff;             // Code in use, write
    logic [ddr_strobe_pkg::WL_W-1:0]      wl_act_ff;              // Setting in use
    logic                                 pol_ff;
    logic                                 pad_bad;
    logic                                 rd_idle;

    // Register decode; answer one cycle after setup, no wait states
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_wl      = wl_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        addr_hit    = (paddr == ddr_strobe_pkg::ADDR_CTRL)   ||
                      (paddr == ddr_strobe_pkg::ADDR_WLDEL)  ||
                      (paddr == ddr_strobe_pkg::ADDR_STATUS) ||
                      (paddr == ddr_strobe_pkg::ADDR_APPLIED);
        wr_access   = psel && penable && pready_ff && pwrite && !pslverr_ff;
        if (psel && !penable) begin
            // Setup cycle: prepare answer for the access phase
            nxt_pready  = 1'b1;
            nxt_pslverr = !addr_hit;
            unique case (paddr)
                ddr_strobe_pkg::ADDR_CTRL:    nxt_prdata = {24'h000000, ctrl_ff};
                ddr_strobe_pkg::ADDR_WLDEL:   nxt_prdata = {24'h000000, wl_ff};
                ddr_strobe_pkg::ADDR_STATUS:  nxt_prdata = {13'h0000, rd_idle, pad_bad,
                                                            pol_ff, 1'b0, cal_code_ff[1],
                                                            1'b0, cal_code_ff[0]};
                ddr_strobe_pkg::ADDR_APPLIED: nxt_prdata = {9'h000, wr_code_ff, wl_act_ff,
                                                            1'b0, rd_code_ff};
                default:                      nxt_prdata = 32'h00000000;
            endcase
        end
        if (wr_access) begin
            // Fabric controller sets the leveling value here
            if (paddr == ddr_strobe_pkg::ADDR_CTRL) begin
                nxt_ctrl = ddr_strobe_pkg::ctrl_t'(pwdata[7:0]);
            end
            if (paddr == ddr_strobe_pkg::ADDR_WLDEL) begin
                nxt_wl = pwdata[ddr_strobe_pkg::WL_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff    <= ddr_strobe_pkg::ctrl_t'(ddr_strobe_pkg::CTRL_RST);
            wl_ff      <= ddr_strobe_pkg::WL_RST;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            wl_ff      <= nxt_wl;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Shared update tick for both loops; slow enough to ride out detector noise
    logic [ddr_strobe_pkg::CAL_CNT_W-1:0] cal_cnt_ff, nxt_cal_cnt;
    logic                                 cal_tick;

    always_comb begin
        cal_tick    = (cal_cnt_ff == ddr_strobe_pkg::CAL_LAST);
        nxt_cal_cnt = cal_tick ? '0 : cal_cnt_ff + 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_ff <= '0;
        end else begin
            cal_cnt_ff <= nxt_cal_cnt;
        end
    end

    // One calibration loop per side, bang-bang up/down on the lag detector
    for (genvar side = 0; side < 2; side++) begin : g_loop
        logic [ddr_strobe_pkg::CODE_W-1:0] nxt_code;

        always_comb begin
            nxt_code = cal_code_ff[side];
            if (cal_tick) begin
                // Saturate rather than wrap: a wrap would jump a full period
                if (lag_s2_ff[side] && cal_code_ff[side] != ddr_strobe_pkg::CODE_MAX) begin
                    nxt_code = cal_code_ff[side] + 1'b1;
                end else if (!lag_s2_ff[side] &&
                             cal_code_ff[side] != ddr_strobe_pkg::CODE_MIN) begin
                    nxt_code = cal_code_ff[side] - 1'b1;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cal_code_ff[side] <= ddr_strobe_pkg::CODE_RST;
            end else begin
                cal_code_ff[side] <= nxt_code;
            end
        end
    end

    // Strobe source, side selection and read delay line
    logic                                 bank_left;   // Group belongs to left loop
    logic [ddr_strobe_pkg::CODE_W-1:0]    side_code;   // Code offered to this group
    logic                                 strb_sel;    // Strobe after pad qualification
    logic [ddr_strobe_pkg::RD_LINE_N-1:0] rd_line_ff, nxt_rd_line;
    logic [ddr_strobe_pkg::CODE_W-1:0]    nxt_rd_code;
    logic                                 rd_out_ff, nxt_rd_out;
    logic                                 rd_rise;
    logic                                 burst_ff, nxt_burst;
    logic                                 half_ff, nxt_half;
    logic                                 nxt_pol, nxt_xfer, xfer_ff;
    logic [ddr_strobe_pkg::DQ_N-1:0]      pads_ff, nxt_pads;

    always_comb begin
        bank_left   = (ctrl_ff.bank == ddr_strobe_pkg::BANK_LEFT_A) ||
                      (ctrl_ff.bank == ddr_strobe_pkg::BANK_LEFT_B) ||
                      (ctrl_ff.bank == ddr_strobe_pkg::BANK_LEFT_C);
        side_code   = bank_left ? cal_code_ff[0] : cal_code_ff[1];
        pad_bad     = !ddr_strobe_pkg::PAD_STROBE_OK[ctrl_ff.pad_sel];
        strb_sel    = pad_s2_ff[ctrl_ff.pad_sel] && !pad_bad;
        nxt_rd_line = {rd_line_ff[ddr_strobe_pkg::RD_LINE_N-2:0], strb_sel};
        // An empty line means no burst is in flight
        rd_idle     = (rd_line_ff == '0) && !strb_sel;
        nxt_rd_code = rd_idle ? side_code : rd_code_ff;
        nxt_rd_out  = rd_line_ff[rd_code_ff];
        rd_rise     = nxt_rd_out && !rd_out_ff;
        nxt_burst   = rd_idle ? 1'b0 : (burst_ff || rd_rise);
        nxt_pol     = pol_ff;
        nxt_half    = rd_idle ? 1'b0 : half_ff;
        nxt_xfer    = 1'b0;
        if (rd_rise) begin
            // First edge of a burst picks the capture phase of the system clock
            if (!burst_ff) begin
                nxt_pol = write_gear_clock_0;
            end
            nxt_half = !half_ff;
            nxt_xfer = ctrl_ff.double_rate_gearbox && half_ff;
        end
        nxt_pads = {nxt_rd_out && ctrl_ff.eleven_pads,
                    {(ddr_strobe_pkg::DQ_N-1){nxt_rd_out}}};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_line_ff <= '0;
            rd_code_ff <= ddr_strobe_pkg::CODE_RST;
            rd_out_ff  <= 1'b0;
            burst_ff   <= 1'b0;
            half_ff    <= 1'b0;
            pol_ff     <= 1'b0;
            xfer_ff    <= 1'b0;
            pads_ff    <= '0;
        end else begin
            rd_line_ff <= nxt_rd_line;
            rd_code_ff <= nxt_rd_code;
            rd_out_ff  <= nxt_rd_out;
            burst_ff   <= nxt_burst;
            half_ff    <= nxt_half;
            pol_ff     <= nxt_pol;
            xfer_ff    <= nxt_xfer;
            pads_ff    <= nxt_pads;
        end
    end

    // Write side: gear clocks, leveled strobe delay line
    logic                                 gc0_ff, gc1_ff;
    logic                                 wr_act_ff, nxt_wr_act;
    logic [ddr_strobe_pkg::WR_LINE_N-1:0] wr_line_ff, nxt_wr_line;
    logic [ddr_strobe_pkg::CODE_W-1:0]    nxt_wr_code;
    logic [ddr_strobe_pkg::WL_W-1:0]      nxt_wl_act;
    logic [ddr_strobe_pkg::WL_W-1:0]      wr_tap;
    logic                                 wr_quiet;
    logic                                 wr_out_ff, nxt_wr_out;

    always_comb begin
        // Settings move only with the generator off and the line drained
        wr_quiet    = !wr_act_ff && (wr_line_ff == '0);
        nxt_wr_act  = ctrl_ff.wr_en;
        nxt_wr_code = wr_quiet ? side_code : wr_code_ff;
        nxt_wl_act  = wr_quiet ? wl_ff : wl_act_ff;
        nxt_wr_line = {wr_line_ff[ddr_strobe_pkg::WR_LINE_N-2:0], wr_act_ff && gc0_ff};
        // Low seven bits give 128 steps on top of the loop code
        wr_tap      = {1'b0, wr_code_ff} +
                      {1'b0, wl_act_ff[ddr_strobe_pkg::WL_W-2:0]};
        nxt_wr_out  = wr_line_ff[wr_tap] ^ wl_act_ff[ddr_strobe_pkg::WL_W-1];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gc0_ff     <= 1'b0;
            gc1_ff     <= 1'b0;
            wr_act_ff  <= 1'b0;
            wr_line_ff <= '0;
            wr_code_ff <= ddr_strobe_pkg::CODE_RST;
            wl_act_ff  <= ddr_strobe_pkg::WL_RST;
            wr_out_ff  <= 1'b0;
        end else begin
            gc0_ff     <= !gc0_ff;
            gc1_ff     <= gc1_ff ^ gc0_ff;
            wr_act_ff  <= nxt_wr_act;
            wr_line_ff <= nxt_wr_line;
            wr_code_ff <= nxt_wr_code;
            wl_act_ff  <= nxt_wl_act;
            wr_out_ff  <= nxt_wr_out;
        end
    end

    // Outputs, all straight from flip-flops
    assign prdata                  = prdata_ff;
    assign pready                  = pready_ff;
    assign pslverr                 = pslverr_ff;
    assign dll_delay_code_left     = cal_code_ff[0];
    assign dll_delay_code_right    = cal_code_ff[1];
    assign read_strobe_delayed     = pads_ff;
    assign capture_clock_polarity  = pol_ff;
    assign gearbox_transfer_strobe = xfer_ff;
    assign write_gear_clock_0      = gc0_ff;
    assign write_gear_clock_1      = gc1_ff;
    assign write_strobe_shifted    = wr_out_ff;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_left_bank;
        rd_idle && bank_left |=> rd_code_ff == $past(cal_code_ff[0]);
    endproperty
    a_left_bank: assert property (p_left_bank) else $error("left bank code wrong");

    property p_cal_step;
        !cal_tick |=> $stable(cal_code_ff[0]) && $stable(cal_code_ff[1]);
    endproperty
    a_cal_step: assert property (p_cal_step) else $error("loop moved off tick");

    property p_rd_delay0;
        // Line empty and strobe just up: the burst's first bit, code at zero
        $rose(strb_sel) && rd_code_ff == ddr_strobe_pkg::CODE_MIN && rd_line_ff == '0
            ##1 rd_code_ff == ddr_strobe_pkg::CODE_MIN
            |-> ##1 read_strobe_delayed[0];
    endproperty
    a_rd_delay0: assert property (p_rd_delay0) else $error("zero delay path late");

    property p_ten_pads;
        !ctrl_ff.eleven_pads ##1 !$changed(ctrl_ff) |-> !read_strobe_delayed[10];
    endproperty
    a_ten_pads: assert property (p_ten_pads) else $error("pad 11 driven");

    property p_gearbox;
        gearbox_transfer_strobe |-> $past(ctrl_ff.double_rate_gearbox) ##1
            !gearbox_transfer_strobe;
    endproperty
    a_gearbox: assert property (p_gearbox) else $error("transfer without gearbox");

    property p_gear_div;
        write_gear_clock_1 != $past(write_gear_clock_1) |-> $past(write_gear_clock_0);
    endproperty
    a_gear_div: assert property (p_gear_div) else $error("gear clock 1 ratio");

    property p_invert;
        wr_quiet && wl_act_ff[ddr_strobe_pkg::WL_W-1] |=> write_strobe_shifted;
    endproperty
    a_invert: assert property (p_invert) else $error("idle strobe not inverted");

    property p_hold_code;
        !rd_idle |=> $stable(rd_code_ff);
    endproperty
    a_hold_code: assert property (p_hold_code) else $error("code changed in burst");

    property p_bad_pad;
        // Nothing from a refused pad may enter the delay line
        $past(pad_bad) |-> !rd_line_ff[0];
    endproperty
    a_bad_pad: assert property (p_bad_pad) else $error("bad pad reached strobe");

endmodule

`default_nettype wire

/* File: pkg/ddr_strobe_pkg.sv */
// Constants, register map and field layout for the DDR strobe delay control block.
// Assumes a 100 MHz APB clock and strobe pads sampled on that clock.
package ddr_strobe_pkg;

    // Widths of codes and settings
    localparam int CODE_W     = 7;   // Calibration code width
    localparam int WL_W       = 8;   // Dynamic write delay width, inversion in the top bit
    localparam int PAD_N      = 4;   // Pads that may be routed to the strobe logic
    localparam int DQ_N       = 11;  // Data pads reached by one strobe group
    localparam int RD_LINE_N  = 128; // Read delay line taps, one per code value
    localparam int WR_LINE_N  = 256; // Write delay line taps, code plus write steps
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_WLDEL   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_APPLIED = 8'h0C;

    // Banks served by the left loop; every other bank goes right
    localparam logic [2:0] BANK_LEFT_A = 3'h0;
    localparam logic [2:0] BANK_LEFT_B = 3'h7;
    localparam logic [2:0] BANK_LEFT_C = 3'h6;

    // Pads wired for strobe duty: pads 0 and 2 only
    localparam logic [PAD_N-1:0] PAD_STROBE_OK = 4'h5;

    // Reset values and code limits
    localparam logic [CODE_W-1:0] CODE_RST = 7'h40;
    localparam logic [WL_W-1:0]   WL_RST   = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MAX = 7'h7F;
    localparam logic [CODE_W-1:0] CODE_MIN = 7'h00;

    // Calibration update interval
    localparam int CLK_PERIOD_NS  = 10;
    localparam int CAL_UPDATE_NS  = 1000;
    localparam int CAL_UPDATE_CYC = CAL_UPDATE_NS / CLK_PERIOD_NS;
    localparam int CAL_CNT_W      = 7;
    localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_UPDATE_CYC - 1);

    // Control register layout, msb first
    typedef struct packed {
        logic [1:0] pad_sel;             // Pad routed to the strobe logic
        logic [2:0] bank;                // Bank of the strobe group
        logic       wr_en;               // Write strobe generation on
        logic       eleven_pads;         // Group has 11 data pads, else 10
        logic       double_rate_gearbox; // Two-stage capture gearbox in use
    } ctrl_t;

    localparam logic [7:0] CTRL_RST = 8'h00;

endpackage

/* File: verification/strobe_source_model.sv */
// Far-side memory model: drives read strobe bursts onto the strobe pads.
// Assumes one fire pulse per burst; pads park low between bursts.
`timescale 1ns/10ps
`default_nettype none
module strobe_source_model (
    input  wire logic       fire,     // Start one burst
    input  wire logic [1:0] pad_pick, // Pad that carries the burst
    output logic      [3:0] pads      // Strobe pads toward the device
);
    // Four 80 ns strobe periods; 3 ns offset keeps phase unrelated to pclk
    initial pads = 4'h0;
    always @(posedge fire) begin
        #3;
        repeat (4) begin
            pads[pad_pick] = 1'b1;
            #40;
            pads[pad_pick] = 1'b0;
            #40;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Testbench for the DDR strobe delay control: APB master, strobe bursts, leveling.
// Assumes zero-wait APB slave and loop codes that saturate while lag is held.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        pclk = 1'b0;     // 100 MHz clock
    logic        presetn = 1'b0;  // Active-low reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic [1:0]  dll_lag = 2'h1;  // Left too short, right too long
    logic [3:0]  pads;
    logic        go = 1'b0;       // Burst request to the memory model
    logic [1:0]  go_pad = 2'h0;
    logic [6:0]  cl, cr;
    logic [10:0] rsd;
    logic        pol, gxfer, g0, g1, wss;
    int          n_fail = 0, num_checks = 0, t0, t1;

    ddr_strobe_delay_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_pad_in(pads),
        .dll_lag(dll_lag), .dll_delay_code_left(cl), .dll_delay_code_right(cr),
        .read_strobe_delayed(rsd), .capture_clock_polarity(pol),
        .gearbox_transfer_strobe(gxfer), .write_gear_clock_0(g0),
        .write_gear_clock_1(g1), .write_strobe_shifted(wss));
    strobe_source_model mem (.fire(go), .pad_pick(go_pad), .pads(pads));

    // Clock
    always #5 pclk = ~pclk;

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        // A slave that never answers ends the run as a failure
        if (pready !== 1'b1) begin
            n_fail++;
            final_report;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One read burst under a given control byte; counts edges and latency
    task automatic burst(input logic [7:0] ctrl, input logic [1:0] pd, input int k,
                         input int e0, input int e10, input int eg);
        int c, lat, n0, n10, ng, nfo;
        logic p0, p10, pg;
        c = 0;
        lat = -1;
        n0 = 0;
        n10 = 0;
        ng = 0;
        nfo = 0;
        p0 = 1'b0;
        p10 = 1'b0;
        pg = 1'b0;
        apb(1'b1, ddr_strobe_pkg::ADDR_CTRL, {24'h0, ctrl});
        repeat (10) @(posedge pclk);
        go_pad <= pd;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (250) begin
            @(posedge pclk);
            c++;
            if (rsd[0] === 1'b1 && p0 === 1'b0) begin
                n0++;
                if (lat < 0) begin
                    lat = c;
                    // Polarity takes gear clock 0 of the cycle before the first rise
                    chk("capture polarity", {31'h0, pg}, {31'h0, pol});
                end
            end
            if (rsd[10] === 1'b1 && p10 === 1'b0) n10++;
            if (gxfer === 1'b1) ng++;
            if (rsd[9:1] !== {9{rsd[0]}}) nfo++;
            p0 = rsd[0];
            p10 = rsd[10];
            pg = g0;
        end
        chk("strobe rises", e0, n0);
        chk("pads in step", 0, nfo);
        chk("eleventh pad rises", e10, n10);
        chk("transfer pulses", eg, ng);
        if (e0 > 0) chk("latency in range", 1, lat >= k + 2 && lat <= k + 6);
    endtask

    // Leveling step as the fabric controller does it
    task automatic lvl(input logic [7:0] wl);
        logic rel, w1;
        logic [7:0] k;
        apb(1'b1, ddr_strobe_pkg::ADDR_CTRL, 32'h0);
        repeat (270) @(posedge pclk);
        apb(1'b1, ddr_strobe_pkg::ADDR_WLDEL, {24'h0, wl});
        repeat (4) @(posedge pclk);
        apb(1'b0, ddr_strobe_pkg::ADDR_APPLIED, 32'h0);
        chk("setting applied", {24'h0, wl}, {24'h0, rd[15:8]});
        k = {1'b0, rd[22:16]} + {1'b0, wl[6:0]} + {7'h0, wl[7]};
        apb(1'b1, ddr_strobe_pkg::ADDR_CTRL, 32'h4);
        repeat (300) @(posedge pclk);
        rel = wss ^ g0;
        w1 = wss;
        @(posedge pclk);
        chk("write strobe toggles", 1, wss !== w1);
        // Two register stages plus the tap: parity of k fixes the phase
        chk("write strobe phase", 32'h0, {31'h0, rel ^ k[0]});
        apb(1'b1, ddr_strobe_pkg::ADDR_WLDEL, 32'h33);
        apb(1'b0, ddr_strobe_pkg::ADDR_APPLIED, 32'h0);
        chk("setting held", {24'h0, wl}, {24'h0, rd[15:8]});
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog well past the expected run of about 11k cycles
    initial begin
        #300000;
        n_fail++;
        final_report;
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ddr_strobe_pkg::ADDR_STATUS, 32'h0);
        chk("reset codes", 32'h4040, rd & 32'h7F7F);
        chk("left code at reset", 32'h40, cl);
        chk("right code at reset", 32'h40, cr);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        t0 = 0; t1 = 0;
        repeat (8) begin
            w_prev: begin
                logic a, b;
                a = g0;
                b = g1;
                @(posedge pclk);
                t0 += (g0 !== a);
                t1 += (g1 !== b);
            end
        end
        chk("gear clock 0 toggles", 8, t0);
        chk("gear clock 1 toggles", 4, t1);
        $display("test registers and gear clocks done");
        repeat (6700) @(posedge pclk);
        apb(1'b0, ddr_strobe_pkg::ADDR_STATUS, 32'h0);
        chk("tracked codes", 32'h007F, rd & 32'h7F7F);
        chk("left loop code", 32'h7F, cl);
        chk("right loop code", 32'h00, cr);
        $display("test loop tracking done");
        burst(8'h03, 2'h0, 127, 4, 4, 2);
        burst(8'h3B, 2'h0, 127, 4, 4, 2);
        burst(8'h33, 2'h0, 127, 4, 4, 2);
        burst(8'h0B, 2'h0, 0, 4, 4, 2);
        burst(8'h13, 2'h0, 0, 4, 4, 2);
        burst(8'h1B, 2'h0, 0, 4, 4, 2);
        burst(8'h88, 2'h2, 0, 4, 0, 0);
        burst(8'h48, 2'h1, 0, 0, 0, 0);
        apb(1'b0, ddr_strobe_pkg::ADDR_STATUS, 32'h0);
        chk("bad pad flag", 1, rd[17]);
        $display("test read strobe done");
        lvl(8'h05);
        lvl(8'h06);
        lvl(8'h85);
        lvl(8'h7F);
        $display("test write leveling done");
        final_report;
    end
endmodule
`default_nettype wire
